/* File: bench/iqp_policer_monitor.sv */
// port assertions of the ingress qos policer
`timescale 1ns/1ps
`default_nettype none
// ==========
// checker
module iqp_policer_monitor (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic [31:0] dat_o,
  // packets in
  input wire logic pkt_vld_i,
  input wire logic [10:0] pkt_len_i,
  input wire logic [15:0] pkt_hit_i,
  input wire logic [2:0] pkt_cos_i,
  input wire logic [5:0] pkt_dscp_i,
  // packets out
  input wire logic fwd_vld_o,
  input wire logic [10:0] fwd_len_o,
  input wire logic [2:0] fwd_cos_o,
  input wire logic [5:0] fwd_dscp_o,
  input wire logic fwd_drop_o,
  input wire logic fwd_match_o,
  input wire logic fwd_exceed_o,
  input wire logic [3:0] fwd_cls_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack not one cycle after request");
  property p_ack1; ack_o |=> !ack_o; endproperty
  a_ack1: assert property (p_ack1) else $error("ack longer than one cycle");
  property p_dat0; !ack_o |-> dat_o == 32'h0; endproperty
  a_dat0: assert property (p_dat0) else $error("read data outside ack");
  property p_lat; pkt_vld_i |-> ##2 fwd_vld_o && fwd_len_o == $past(pkt_len_i, 2); endproperty
  a_lat: assert property (p_lat) else $error("descriptor lost or length changed");
  property p_nolat; fwd_vld_o |-> $past(pkt_vld_i, 2); endproperty
  a_nolat: assert property (p_nolat) else $error("spurious output descriptor");
  property p_pass;
    fwd_vld_o && !fwd_match_o |-> fwd_cos_o == $past(pkt_cos_i, 2)
      && fwd_dscp_o == $past(pkt_dscp_i, 2) && !fwd_drop_o && fwd_cls_o == 4'h0;
  endproperty
  a_pass: assert property (p_pass) else $error("unmatched packet altered");
  property p_nohit; pkt_vld_i && pkt_hit_i == 16'h0 |-> ##2 !fwd_match_o; endproperty
  a_nohit: assert property (p_nohit) else $error("match without criteria hit");
  property p_drop; fwd_vld_o && fwd_drop_o |-> fwd_exceed_o && fwd_match_o; endproperty
  a_drop: assert property (p_drop) else $error("drop without exceed");
  property p_exc; fwd_vld_o && fwd_exceed_o && !fwd_drop_o |-> fwd_cos_o == $past(pkt_cos_i, 2);
  endproperty
  a_exc: assert property (p_exc) else $error("exceeding packet cos changed");
  c_drop: cover property (fwd_vld_o && fwd_drop_o);
  c_exc: cover property (fwd_vld_o && fwd_exceed_o && !fwd_drop_o);
  c_match: cover property (fwd_vld_o && fwd_match_o && !fwd_exceed_o);
endmodule // iqp_policer_monitor

bind iqp_policer iqp_policer_monitor mon (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .ack_o(ack_o), .dat_o(dat_o), .pkt_vld_i(pkt_vld_i), .pkt_len_i(pkt_len_i),
  .pkt_hit_i(pkt_hit_i), .pkt_cos_i(pkt_cos_i), .pkt_dscp_i(pkt_dscp_i),
  .fwd_vld_o(fwd_vld_o), .fwd_len_o(fwd_len_o), .fwd_cos_o(fwd_cos_o),
  .fwd_dscp_o(fwd_dscp_o), .fwd_drop_o(fwd_drop_o), .fwd_match_o(fwd_match_o),
  .fwd_exceed_o(fwd_exceed_o), .fwd_cls_o(fwd_cls_o));
`default_nettype wire

/* File: bench/iqp_policer_tb.sv */
// self-checking testbench of the ingress qos policer
`timescale 1ns/1ps
`default_nettype none
// ==========
// bench top
module iqp_policer_tb;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ack_o, pkt_vld_i, fwd_vld_o;
  logic fwd_drop_o, fwd_match_o, fwd_exceed_o;
  logic [11:0] adr_i = 0;
  logic [3:0] sel_i = 0, fwd_cls_o;
  logic [31:0] dat_i = 0, dat_o, q;
  logic [1:0] pkt_port_i, fwd_port_o;
  logic [10:0] pkt_len_i, fwd_len_o;
  logic [15:0] pkt_hit_i;
  logic [2:0] pkt_cos_i, fwd_cos_o;
  logic [5:0] pkt_dscp_i, fwd_dscp_o;
  int n_fail = 0, check_count = 0;
  iqp_policer dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .pkt_vld_i(pkt_vld_i), .pkt_port_i(pkt_port_i), .pkt_len_i(pkt_len_i),
    .pkt_hit_i(pkt_hit_i), .pkt_cos_i(pkt_cos_i), .pkt_dscp_i(pkt_dscp_i),
    .fwd_vld_o(fwd_vld_o), .fwd_port_o(fwd_port_o), .fwd_len_o(fwd_len_o),
    .fwd_cos_o(fwd_cos_o), .fwd_dscp_o(fwd_dscp_o), .fwd_drop_o(fwd_drop_o),
    .fwd_match_o(fwd_match_o), .fwd_cls_o(fwd_cls_o), .fwd_exceed_o(fwd_exceed_o));
  iqp_port_model pm (.clk_i(clk_i), .vld_o(pkt_vld_i), .port_o(pkt_port_i), .len_o(pkt_len_i),
    .hit_o(pkt_hit_i), .cos_o(pkt_cos_i), .dscp_o(pkt_dscp_i));
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  // ==========
  // tasks
  task end_of_test;
    begin
      if (n_fail == 0 && check_count > 0) begin
        $display("Run complete: PASS");
      end else begin
        $display("Run complete: FAIL");
      end
      $finish;
    end
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    begin
      check_count++;
      if (g !== e) begin
        n_fail++;
        $display("Error %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task wb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    begin
      n = 0;
      {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, s};
      @(posedge clk_i);
      while (ack_o !== 1'b1) begin
        n++;
        if (n > 20) begin
          n_fail++;
          end_of_test;
        end
        @(posedge clk_i);
      end
      q = dat_o;
      {cyc_i, stb_i} <= 2'b00;
      @(posedge clk_i);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hf);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    begin
      wb(1'b0, a, 32'h0, 4'hf);
      chk("read data", e, q);
    end
  endtask
  // expected e: cos, dscp, drop, match, exceed, class
  task pk(input logic [1:0] p, input logic [10:0] l, input logic [15:0] h, input logic [15:0] e);
    begin
      pm.send(p, l, h);
      repeat (2) @(posedge clk_i);
      chk("forwarded descriptor", {13'h0, p, 1'b1, e}, {13'h0, fwd_port_o, fwd_vld_o,
        fwd_cos_o, fwd_dscp_o, fwd_drop_o, fwd_match_o, fwd_exceed_o, fwd_cls_o});
    end
  endtask
  // ==========
  // scenarios
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    rd(12'h000, 32'h0);
    rd(12'h300, 32'h0);
    rd(12'hffc, 32'h0);
    wr(12'h008, 32'h51);
    wr(12'h108, 32'h8);
    pk(0, 64, 16'h8, {3'h1, 6'h01, 3'b000, 4'h0});
    wr(12'h300, 32'h1);
    pk(0, 64, 16'h8, {3'h5, 6'h01, 3'b010, 4'h2});
    pk(0, 64, 16'h0, {3'h1, 6'h01, 3'b000, 4'h0});
    wr(12'h004, 32'ha5);
    wr(12'h104, 32'h18);
    pk(0, 64, 16'h8, {3'h1, 6'h0a, 3'b010, 4'h1});
    wr(12'h03c, 32'h71);
    wr(12'h13c, 32'h8000);
    pk(0, 64, 16'h8000, {3'h7, 6'h01, 3'b010, 4'hf});
    // empty meter with drop, then the lowered dscp instead
    wr(12'h400, 32'h0);
    wr(12'h004, 32'haf);
    pk(0, 64, 16'h8, {3'h1, 6'h01, 3'b111, 4'h1});
    rd(12'h400, 32'h1);
    rd(12'h404, 32'h5);
    wr(12'h004, 32'ha8a7);
    pk(0, 64, 16'h8, {3'h1, 6'h2a, 3'b011, 4'h1});
    // policy 1 shared by ports 0 and 1
    wr(12'h040, 32'h31);
    wr(12'h140, 32'h1);
    wr(12'h304, 32'h3);
    pk(1, 64, 16'h1, {3'h3, 6'h01, 3'b010, 4'h0});
    pk(0, 64, 16'h1, {3'h1, 6'h01, 3'b000, 4'h0});
    wb(1'b1, 12'h300, 32'h3, 4'h1);
    pk(0, 64, 16'h1, {3'h3, 6'h01, 3'b010, 4'h0});
    // 100000 kbps earns one byte per 10 cycles, bucket 64 bytes
    wr(12'h240, 32'h8186a0);
    wr(12'h040, 32'h3b);
    repeat (700) @(posedge clk_i);
    pk(1, 65, 16'h1, {3'h1, 6'h01, 3'b111, 4'h0});
    pk(1, 64, 16'h1, {3'h3, 6'h01, 3'b010, 4'h0});
    pk(1, 64, 16'h1, {3'h1, 6'h01, 3'b111, 4'h0});
    // port cap 10000 kbps: only about 7 bytes earned in 700 cycles
    wr(12'h304, 32'h271003);
    repeat (700) @(posedge clk_i);
    pk(1, 64, 16'h1, {3'h1, 6'h01, 3'b111, 4'h0});
    end_of_test;
  end
endmodule // iqp_policer_tb
`default_nettype wire

/* File: bench/iqp_port_model.sv */
// ingress port model feeding descriptors to the policer
`timescale 1ns/1ps
`default_nettype none
// ==========
// model
module iqp_port_model (
  // clock
  input wire logic clk_i,
  // descriptor out
  output logic vld_o,
  output logic [1:0] port_o,
  output logic [10:0] len_o,
  output logic [15:0] hit_o,
  output logic [2:0] cos_o,
  output logic [5:0] dscp_o
);
  initial {vld_o, port_o, len_o, hit_o, cos_o, dscp_o} = '0;
  // idle fields show the inverse so stale values are never mistaken for a descriptor
  task send(input logic [1:0] p, input logic [10:0] l, input logic [15:0] h);
    begin
      vld_o <= 1'b1;
      {port_o, len_o, hit_o, cos_o, dscp_o} <= {p, l, h, 3'h1, 6'h01};
      @(posedge clk_i);
      vld_o <= 1'b0;
      {port_o, len_o, hit_o, cos_o, dscp_o} <= ~{p, l, h, 3'h1, 6'h01};
    end
  endtask
endmodule // iqp_port_model
`default_nettype wire

/* File: logic/iqp_defines.vh */
// constants of the ingress qos policer: sizes, register map, field positions, timing
`ifndef IQP_DEFINES_VH
`define IQP_DEFINES_VH

// ==========================================================
// sizes
`define IQP_NPORT 4
`define IQP_NPOL 2
`define IQP_NCLS 16
`define IQP_NITEM 16
`define IQP_NMTR 64

// ==========================================================
// register regions, selected by adr_i[11:7]
`define IQP_RGN_CFG 5'h00
`define IQP_RGN_MASK 5'h02
`define IQP_RGN_METER 5'h04
`define IQP_RGN_PORT 5'h06
`define IQP_RGN_STAT 5'h08
`define IQP_STAT_DROP 3'h0
`define IQP_STAT_FWD 3'h1

// ==========================================================
// class config word
`define IQP_CFG_VALID 0
`define IQP_CFG_METER_EN 1
`define IQP_CFG_MARK_DSCP 2
`define IQP_CFG_DROP 3
`define IQP_CFG_VAL_LSB 4
`define IQP_CFG_EXC_LSB 10
`define IQP_CFG_RST 16'h0000

// meter word: rate kbps [16:0], burst bytes [27:17]
`define IQP_MTR_RATE_LSB 0
`define IQP_MTR_BURST_LSB 17
`define IQP_MTR_RST 28'h0000000

// port word: enable [0], policy select [1], port speed kbps [24:8], 0 = no cap
`define IQP_PORT_EN 0
`define IQP_PORT_SEL 1
`define IQP_PORT_SPD_LSB 8

// ==========================================================
// timing: one token byte is earned per IQP_TOKEN_DIV units of rate*cycles
`define IQP_CLK_HZ 125000000
`define IQP_BYTES_PER_KB 125
`define IQP_TOKEN_DIV (`IQP_CLK_HZ / `IQP_BYTES_PER_KB)

`endif

/* File: logic/iqp_meter.v */
// single token bucket meter, one byte per token
`timescale 1ns/1ps
`default_nettype none
`include "iqp_defines.vh"

module iqp_meter (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // configuration
  input wire [16:0] rate_i,
  input wire [10:0] burst_i,
  // packet
  input wire [10:0] len_i,
  input wire take_i,
  output wire ok_o
);

  localparam integer DIV_INT = `IQP_TOKEN_DIV;
  localparam [20:0] DIV = DIV_INT[20:0];

  reg [20:0] acc_r;
  reg [10:0] tok_r;
  reg [10:0] tok_nxt;
  wire [20:0] acc_sum;
  wire earn;

  // rate stays below DIV, so at most one token per cycle
  assign acc_sum = acc_r + {4'h0, rate_i};
  assign earn = (acc_sum >= DIV);
  assign ok_o = (tok_r >= len_i);

  always @* begin
    tok_nxt = tok_r;
    if (take_i) begin
      tok_nxt = tok_nxt - len_i;
    end
    if (earn && (tok_nxt < burst_i)) begin
      tok_nxt = tok_nxt + 11'h001;
    end
    // depth follows the burst setting, also when it is lowered
    if (tok_nxt > burst_i) begin
      tok_nxt = burst_i;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      acc_r <= 21'h000000;
      tok_r <= 11'h000;
    end else begin
      acc_r <= earn ? (acc_sum - DIV) : acc_sum;
      tok_r <= tok_nxt;
    end
  end

endmodule // iqp_meter

`default_nettype wire

/* File: logic/iqp_policer.v */
// ingress qos policer: classify, remark and meter per port, wishbone registers
// Behaviour
// - each metered class is policed by a token bucket whose depth is the burst setting in bytes.
// - tokens are earned at the class rate in kbps, capped at the port speed when that is lower.
// - a matching packet that is not over the rate gets its cos or its dscp rewritten, as the class selects.
// - with exceed action drop, a packet over the rate is discarded.
// - rate limiting and exceed handling act only when the class meter enable is set.
// - each port holds one policy selection, and writing a new one replaces the old.
// - policies act on ingress traffic only; no egress binding exists.
// - a policy holds at most 16 classes, each with its own remark and meter.
// - 64 policers are provided, one per port and class.
// - a port classifies, remarks and polices only while its enable is set.
// - a policy has no effect until a port enables and selects it.
// - one policy may serve many ports, each port metering on its own.
// - remark and meter act only on packets that meet the class criteria.
// - each class selects up to 16 match items.
// - instead of a drop, traffic over the rate may be lowered to a set dscp.
//
// Register access over Wishbone and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "iqp_defines.vh"

module iqp_policer (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // wishbone slave
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [11:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  // packets from the ingress ports
  input wire pkt_vld_i,
  input wire [1:0] pkt_port_i,
  input wire [10:0] pkt_len_i,
  input wire [15:0] pkt_hit_i,
  input wire [2:0] pkt_cos_i,
  input wire [5:0] pkt_dscp_i,
  // packets to the forwarding engine
  output reg fwd_vld_o,
  output reg [1:0] fwd_port_o,
  output reg [10:0] fwd_len_o,
  output reg [2:0] fwd_cos_o,
  output reg [5:0] fwd_dscp_o,
  output reg fwd_drop_o,
  output reg fwd_match_o,
  output reg [3:0] fwd_cls_o,
  output reg fwd_exceed_o
);

  // ==========================================================
  // configuration storage
  reg [15:0] cfg_r [0:31];
  reg [15:0] mask_r [0:31];
  reg [27:0] meter_r [0:31];
  reg [3:0] port_en_r;
  reg [3:0] port_sel_r;
  reg [16:0] port_spd_r [0:3];
  reg [31:0] drop_cnt_r;
  reg [31:0] fwd_cnt_r;

  // ==========================================================
  // input stage
  reg in_vld_r;
  reg [1:0] in_port_r;
  reg [10:0] in_len_r;
  reg [15:0] in_hit_r;
  reg [2:0] in_cos_r;
  reg [5:0] in_dscp_r;

  always @(posedge clk_i) begin
    if (rst_i) begin
      in_vld_r <= 1'b0;
      in_port_r <= 2'h0;
      in_len_r <= 11'h000;
      in_hit_r <= 16'h0000;
      in_cos_r <= 3'h0;
      in_dscp_r <= 6'h00;
    end else begin
      // this stage sits on the ingress path only, nothing egress reaches it
      in_vld_r <= pkt_vld_i;
      in_port_r <= pkt_port_i;
      in_len_r <= pkt_len_i;
      in_hit_r <= pkt_hit_i;
      in_cos_r <= pkt_cos_i;
      in_dscp_r <= pkt_dscp_i;
    end
  end

  // ==========================================================
  // classification
  reg cls_hit;
  reg [3:0] cls_num;
  reg [4:0] cls_idx;
  reg [4:0] scan_idx;
  reg [4:0] k;
  wire cur_pol;

  assign cur_pol = port_sel_r[in_port_r];

  always @* begin
    cls_hit = 1'b0;
    cls_num = 4'h0;
    scan_idx = 5'h00;
    // scan downward so the lowest matching class is the one kept
    for (k = 5'd16; k != 5'd0; k = k - 5'd1) begin
      scan_idx = {cur_pol, k[3:0] - 4'h1};
      if (cfg_r[scan_idx][`IQP_CFG_VALID] && ((mask_r[scan_idx] & in_hit_r) != 16'h0000)) begin
        cls_hit = 1'b1;
        cls_num = k[3:0] - 4'h1;
      end
    end
    cls_idx = {cur_pol, cls_num};
  end

  // ==========================================================
  // meters, one per port and class
  wire [63:0] mtr_ok;
  wire [5:0] mtr_sel;
  wire [15:0] sel_cfg;
  wire act;
  wire metered;
  wire conform;

  assign mtr_sel = {in_port_r, cls_num};
  assign sel_cfg = cfg_r[cls_idx];
  // a disabled port, or one without a usable class, passes traffic untouched
  assign act = in_vld_r && port_en_r[in_port_r] && cls_hit;
  assign metered = sel_cfg[`IQP_CFG_METER_EN];
  assign conform = !metered || mtr_ok[mtr_sel];

  genvar g;
  generate
    for (g = 0; g < `IQP_NMTR; g = g + 1) begin : g_mtr
      localparam [5:0] GI = g;
      wire [4:0] cidx;
      wire [27:0] mw;
      wire [16:0] rate;
      wire [16:0] spd;
      wire [16:0] eff;
      wire take;
      // the meter tracks the port's current policy, so each port meters alone
      assign cidx = {port_sel_r[g / 16], GI[3:0]};
      assign mw = meter_r[cidx];
      assign rate = mw[`IQP_MTR_RATE_LSB +: 17];
      assign spd = port_spd_r[g / 16];
      assign eff = ((spd != 17'h00000) && (spd < rate)) ? spd : rate;
      assign take = act && metered && mtr_ok[g] && (mtr_sel == GI);
      iqp_meter u_mtr (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .rate_i(eff),
        .burst_i(mw[`IQP_MTR_BURST_LSB +: 11]),
        .len_i(in_len_r),
        .take_i(take),
        .ok_o(mtr_ok[g])
      );
    end
  endgenerate

  // ==========================================================
  // remark and exceed decision
  reg [2:0] cos_nxt;
  reg [5:0] dscp_nxt;
  reg drop_nxt;
  reg exceed_nxt;

  always @* begin
    cos_nxt = in_cos_r;
    dscp_nxt = in_dscp_r;
    drop_nxt = 1'b0;
    exceed_nxt = 1'b0;
    if (act) begin
      if (conform) begin
        if (sel_cfg[`IQP_CFG_MARK_DSCP]) begin
          dscp_nxt = sel_cfg[`IQP_CFG_VAL_LSB +: 6];
        end else begin
          cos_nxt = sel_cfg[`IQP_CFG_VAL_LSB +: 3];
        end
      end else begin
        exceed_nxt = 1'b1;
        if (sel_cfg[`IQP_CFG_DROP]) begin
          drop_nxt = 1'b1;
        end else begin
          dscp_nxt = sel_cfg[`IQP_CFG_EXC_LSB +: 6];
        end
      end
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      fwd_vld_o <= 1'b0;
      fwd_port_o <= 2'h0;
      fwd_len_o <= 11'h000;
      fwd_cos_o <= 3'h0;
      fwd_dscp_o <= 6'h00;
      fwd_drop_o <= 1'b0;
      fwd_match_o <= 1'b0;
      fwd_cls_o <= 4'h0;
      fwd_exceed_o <= 1'b0;
    end else begin
      fwd_vld_o <= in_vld_r;
      fwd_port_o <= in_port_r;
      fwd_len_o <= in_len_r;
      fwd_cos_o <= cos_nxt;
      fwd_dscp_o <= dscp_nxt;
      fwd_drop_o <= drop_nxt;
      fwd_match_o <= act;
      fwd_cls_o <= act ? cls_num : 4'h0;
      fwd_exceed_o <= exceed_nxt;
    end
  end

  // ==========================================================
  // wishbone register access
  wire req;
  wire wr;
  wire [4:0] rgn;
  wire [4:0] ridx;
  wire [1:0] pidx;
  wire [31:0] bmask;
  wire [31:0] port_word;
  reg [31:0] rd_nxt;
  integer i;

  // one wait state: ack rises in the cycle after the request is seen
  // writes land on the edge that samples ack, while the master still holds the request
  assign req = cyc_i && stb_i && !ack_o;
  assign wr = cyc_i && stb_i && we_i && ack_o;
  assign rgn = adr_i[11:7];
  assign ridx = adr_i[6:2];
  assign pidx = adr_i[3:2];
  assign bmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  assign port_word = {7'h00, port_spd_r[pidx], 6'h00, port_sel_r[pidx], port_en_r[pidx]};

  always @* begin
    rd_nxt = 32'h00000000;
    if (rgn == `IQP_RGN_CFG) begin
      rd_nxt = {16'h0000, cfg_r[ridx]};
    end else if (rgn == `IQP_RGN_MASK) begin
      rd_nxt = {16'h0000, mask_r[ridx]};
    end else if (rgn == `IQP_RGN_METER) begin
      rd_nxt = {4'h0, meter_r[ridx]};
    end else if ((rgn == `IQP_RGN_PORT) && (adr_i[6:4] == 3'h0)) begin
      rd_nxt = port_word;
    end else if ((rgn == `IQP_RGN_STAT) && (adr_i[6:2] == {2'h0, `IQP_STAT_DROP})) begin
      rd_nxt = drop_cnt_r;
    end else if ((rgn == `IQP_RGN_STAT) && (adr_i[6:2] == {2'h0, `IQP_STAT_FWD})) begin
      rd_nxt = fwd_cnt_r;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= req;
      dat_o <= req ? rd_nxt : 32'h00000000;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      for (i = 0; i < 32; i = i + 1) begin
        cfg_r[i] <= `IQP_CFG_RST;
        mask_r[i] <= 16'h0000;
        meter_r[i] <= `IQP_MTR_RST;
      end
      for (i = 0; i < 4; i = i + 1) begin
        port_spd_r[i] <= 17'h00000;
      end
      port_en_r <= 4'h0;
      port_sel_r <= 4'h0;
    end else if (wr) begin
      if (rgn == `IQP_RGN_CFG) begin
        cfg_r[ridx] <= (cfg_r[ridx] & ~bmask[15:0]) | (dat_i[15:0] & bmask[15:0]);
      end else if (rgn == `IQP_RGN_MASK) begin
        mask_r[ridx] <= (mask_r[ridx] & ~bmask[15:0]) | (dat_i[15:0] & bmask[15:0]);
      end else if (rgn == `IQP_RGN_METER) begin
        meter_r[ridx] <= (meter_r[ridx] & ~bmask[27:0]) | (dat_i[27:0] & bmask[27:0]);
      end else if ((rgn == `IQP_RGN_PORT) && (adr_i[6:4] == 3'h0)) begin
        if (sel_i[0]) begin
          port_en_r[pidx] <= dat_i[`IQP_PORT_EN];
          port_sel_r[pidx] <= dat_i[`IQP_PORT_SEL];
        end
        if (sel_i[1] && sel_i[2] && sel_i[3]) begin
          port_spd_r[pidx] <= dat_i[`IQP_PORT_SPD_LSB +: 17];
        end
      end
    end
  end

  // ==========================================================
  // statistics; a write clears, but a packet in the same cycle still counts
  wire clr_drop;
  wire clr_fwd;
  wire ev_drop;
  wire ev_fwd;

  assign clr_drop = wr && (rgn == `IQP_RGN_STAT) && (adr_i[6:2] == {2'h0, `IQP_STAT_DROP});
  assign clr_fwd = wr && (rgn == `IQP_RGN_STAT) && (adr_i[6:2] == {2'h0, `IQP_STAT_FWD});
  assign ev_drop = in_vld_r && drop_nxt;
  assign ev_fwd = in_vld_r && !drop_nxt;

  always @(posedge clk_i) begin
    if (rst_i) begin
      drop_cnt_r <= 32'h00000000;
      fwd_cnt_r <= 32'h00000000;
    end else begin
      if (clr_drop) begin
        drop_cnt_r <= {31'h00000000, ev_drop};
      end else if (ev_drop) begin
        drop_cnt_r <= drop_cnt_r + 32'h00000001;
      end
      if (clr_fwd) begin
        fwd_cnt_r <= {31'h00000000, ev_fwd};
      end else if (ev_fwd) begin
        fwd_cnt_r <= fwd_cnt_r + 32'h00000001;
      end
    end
  end

endmodule // iqp_policer

`default_nettype wire
